// *** amm_cfg.svh ***
// offsets, field positions, reset values for the min/max tracker
`ifndef AMM_CFG_SVH
`define AMM_CFG_SVH

// register byte addresses
`define AMM_ADR_CTRL     8'h00
`define AMM_ADR_UPPER    8'h04
`define AMM_ADR_LOWER    8'h08
`define AMM_ADR_MIN      8'h0c
`define AMM_ADR_MAX      8'h10
`define AMM_ADR_RESULT   8'h14
`define AMM_ADR_STATUS   8'h18

// control register fields
`define AMM_CTRL_MODE_LSB 0
`define AMM_CTRL_MODE_MSB 1
`define AMM_CTRL_RSTDIS   2
`define AMM_CTRL_FROMBLK  3
`define AMM_CTRL_CLEAR    4

// reset values
`define AMM_CTRL_RST     4'h0
`define AMM_UPPER_RST    16'h7fff
`define AMM_LOWER_RST    16'h8000
`define AMM_ZERO         16'h0000

`endif

// *** amm_min_max.sv ***
// min/max tracker with clamp and wishbone register slave
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "amm_cfg.svh"

module amm_min_max
	import amm_pkg::*;
#(
	parameter int DATA_W = 16
) (
	input  wire logic                     clock_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     cycle_strobe_i,
	input  wire logic                     enable_i,
	input  wire logic                     extreme_select_i,
	input  wire logic signed [DATA_W-1:0] analog_source_value_i,
	output logic signed [DATA_W-1:0]      analog_result_o,
	input  wire logic                     wb_cyc_i,
	input  wire logic                     wb_stb_i,
	input  wire logic                     wb_we_i,
	input  wire logic [7:0]               wb_adr_i,
	input  wire logic [3:0]               wb_sel_i,
	input  wire logic [31:0]              wb_dat_i,
	output logic [31:0]                   wb_dat_o,
	output logic                          wb_ack_o
);

	localparam int NBYTE = DATA_W / 8;
	localparam logic [DATA_W-1:0] UPPER_RST = DATA_W'(`AMM_UPPER_RST);
	localparam logic [DATA_W-1:0] LOWER_RST = DATA_W'(`AMM_LOWER_RST);
	localparam logic [DATA_W-1:0] ZERO_VAL  = DATA_W'(`AMM_ZERO);

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	wire rst_n = rst_sync_q;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic                     ack_q;
	logic [31:0]              rdat_q;
	logic [31:0]              rdat_d;
	amm_ctrl_type             ctrl_q;
	logic [DATA_W-1:0]        upper_q;
	logic [DATA_W-1:0]        lower_q;
	logic signed [DATA_W-1:0] min_q;
	logic signed [DATA_W-1:0] max_q;
	logic signed [DATA_W-1:0] result_q;
	logic                     valid_q;
	logic                     show_max_q;
	logic                     sel_prev_q;

	wire bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
	wire bus_wr    = bus_req & wb_we_i;
	wire hit_ctrl  = (wb_adr_i == `AMM_ADR_CTRL);
	wire hit_upper = (wb_adr_i == `AMM_ADR_UPPER);
	wire hit_lower = (wb_adr_i == `AMM_ADR_LOWER);
	wire wr_ctrl   = bus_wr & hit_ctrl & wb_sel_i[0];
	wire wr_upper  = bus_wr & hit_upper;
	wire wr_lower  = bus_wr & hit_lower;
	wire soft_clr  = wr_ctrl & wb_dat_i[`AMM_CTRL_CLEAR];

	amm_ctrl_type ctrl_wdata;

	assign ctrl_wdata.from_block = wb_dat_i[`AMM_CTRL_FROMBLK];
	assign ctrl_wdata.rst_on_dis = wb_dat_i[`AMM_CTRL_RSTDIS];
	assign ctrl_wdata.mode       = amm_mode_type'(wb_dat_i[`AMM_CTRL_MODE_MSB:`AMM_CTRL_MODE_LSB]);

	// ------------------------------------------------------------
	// bus answer
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q  <= bus_req;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	amm_stat_type stat;

	assign stat.valid    = valid_q;
	assign stat.show_max = show_max_q;
	assign stat.enable   = enable_i;

	// ------------------------------------------------------------
	// read selection
	// ------------------------------------------------------------
	always_comb begin
		rdat_d = 32'h0000_0000;
		if (!bus_req || wb_we_i) begin
			rdat_d = 32'h0000_0000;
		end else if (hit_ctrl) begin
			rdat_d = {28'h000_0000, ctrl_q};
		end else if (hit_upper) begin
			rdat_d = {{(32-DATA_W){upper_q[DATA_W-1]}}, upper_q};
		end else if (hit_lower) begin
			rdat_d = {{(32-DATA_W){lower_q[DATA_W-1]}}, lower_q};
		end else if (wb_adr_i == `AMM_ADR_MIN) begin
			rdat_d = {{(32-DATA_W){min_q[DATA_W-1]}}, min_q};
		end else if (wb_adr_i == `AMM_ADR_MAX) begin
			rdat_d = {{(32-DATA_W){max_q[DATA_W-1]}}, max_q};
		end else if (wb_adr_i == `AMM_ADR_RESULT) begin
			rdat_d = {{(32-DATA_W){result_q[DATA_W-1]}}, result_q};
		end else if (wb_adr_i == `AMM_ADR_STATUS) begin
			rdat_d = {29'h0000_0000, stat};
		end else begin
			rdat_d = 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= amm_ctrl_type'(`AMM_CTRL_RST);
		end else if (wr_ctrl) begin
			ctrl_q <= ctrl_wdata;
		end
	end

	// limits written per byte lane
	genvar b;
	generate
		for (b = 0; b < NBYTE; b++) begin : g_lane
			always_ff @(posedge clock_i or negedge rst_n) begin
				if (!rst_n) begin
					upper_q[8*b +: 8] <= UPPER_RST[8*b +: 8];
					lower_q[8*b +: 8] <= LOWER_RST[8*b +: 8];
				end else begin
					if (wr_upper && wb_sel_i[b]) begin
						upper_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
					end
					if (wr_lower && wb_sel_i[b]) begin
						lower_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// select edge tracking
	// ------------------------------------------------------------
	wire sel_mode  = (ctrl_q.mode == AMM_MODE_SEL) & ~ctrl_q.from_block;
	wire sel_rise  = extreme_select_i & ~sel_prev_q;
	wire sel_fall  = ~extreme_select_i & sel_prev_q;
	wire show_max_d = !sel_mode ? show_max_q :
		sel_rise ? 1'b1 :
		sel_fall ? 1'b0 : show_max_q;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			sel_prev_q <= 1'b0;
			show_max_q <= 1'b0;
		end else begin
			sel_prev_q <= extreme_select_i;
			show_max_q <= show_max_d;
		end
	end

	// ------------------------------------------------------------
	// extreme tracking
	// ------------------------------------------------------------
	wire signed [DATA_W-1:0] samp = analog_source_value_i;
	wire signed [DATA_W-1:0] lo   = lower_q;
	wire signed [DATA_W-1:0] hi   = upper_q;

	wire dis_reset = cycle_strobe_i & ~enable_i & ctrl_q.rst_on_dis;
	wire track     = cycle_strobe_i & enable_i;
	wire fresh     = ~valid_q | soft_clr;

	wire signed [DATA_W-1:0] min_d =
		(fresh || samp < min_q) ? samp : min_q;
	wire signed [DATA_W-1:0] max_d =
		(fresh || samp > max_q) ? samp : max_q;

	// a sample in the same cycle as a clear starts a new record
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			valid_q <= 1'b0;
			min_q   <= ZERO_VAL;
			max_q   <= ZERO_VAL;
		end else if (track) begin
			valid_q <= 1'b1;
			min_q   <= min_d;
			max_q   <= max_d;
		end else if (dis_reset || soft_clr) begin
			valid_q <= 1'b0;
			min_q   <= ZERO_VAL;
			max_q   <= ZERO_VAL;
		end
	end

	// ------------------------------------------------------------
	// output selection
	// ------------------------------------------------------------
	logic signed [DATA_W-1:0] pick;

	always_comb begin
		pick = samp;
		case (ctrl_q.mode)
			AMM_MODE_MIN: begin
				pick = min_d;
			end
			AMM_MODE_MAX: begin
				pick = max_d;
			end
			AMM_MODE_SEL: begin
				pick = show_max_d ? max_d : min_d;
			end
			default: begin
				pick = samp;
			end
		endcase
		if (ctrl_q.from_block) begin
			pick = samp;
		end
	end

	// ------------------------------------------------------------
	// clamp
	// ------------------------------------------------------------
	wire signed [DATA_W-1:0] low_cut = (pick < lo) ? lo : pick;
	wire signed [DATA_W-1:0] clamped = (low_cut > hi) ? hi : low_cut;

	// ------------------------------------------------------------
	// result register
	// ------------------------------------------------------------
	logic signed [DATA_W-1:0] result_d;

	always_comb begin
		result_d = result_q;
		if (!cycle_strobe_i) begin
			result_d = result_q;
		end else if (enable_i) begin
			result_d = clamped;
		end else if (ctrl_q.rst_on_dis) begin
			result_d = ZERO_VAL;
		end else begin
			result_d = result_q;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= ZERO_VAL;
		end else begin
			result_q <= result_d;
		end
	end

	assign analog_result_o = result_q;

endmodule : amm_min_max
`default_nettype wire

// *** amm_min_max_properties.sv ***
// checker of the min/max tracker ports
`timescale 1ns/1ns
`default_nettype none
`include "amm_cfg.svh"
module amm_min_max_properties #(
	parameter int DATA_W = 16
) (
	input wire logic                     clock_i,
	input wire logic                     rst_n_i,
	input wire logic                     cycle_strobe_i,
	input wire logic                     enable_i,
	input wire logic signed [DATA_W-1:0] analog_source_value_i,
	input wire logic signed [DATA_W-1:0] analog_result_o,
	input wire logic                     wb_cyc_i,
	input wire logic                     wb_stb_i,
	input wire logic                     wb_we_i,
	input wire logic [7:0]               wb_adr_i,
	input wire logic [3:0]               wb_sel_i,
	input wire logic [31:0]              wb_dat_i,
	input wire logic                     wb_ack_o
);
	// ------
	// shadow of control and limits
	// ------
	logic [3:0]               ctrl_q;
	logic signed [DATA_W-1:0] up_q, lo_q, lc_w, cl_w;
	logic                     wr_w, live_w, min_w, max_w;
	assign wr_w = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
	assign live_w = ctrl_q[3] || ctrl_q[1:0] == 2'h3;
	assign min_w = !ctrl_q[3] && ctrl_q[1:0] == 2'h0;
	assign max_w = !ctrl_q[3] && ctrl_q[1:0] == 2'h1;
	assign lc_w = analog_source_value_i < lo_q ? lo_q : analog_source_value_i;
	assign cl_w = lc_w > up_q ? up_q : lc_w;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= `AMM_CTRL_RST;
			up_q <= `AMM_UPPER_RST;
			lo_q <= `AMM_LOWER_RST;
		end else begin
			if (wr_w && wb_adr_i == `AMM_ADR_CTRL && wb_sel_i[0])
				ctrl_q <= wb_dat_i[3:0];
			if (wr_w && wb_adr_i == `AMM_ADR_UPPER && wb_sel_i[1:0] == 2'h3)
				up_q <= wb_dat_i[DATA_W-1:0];
			if (wr_w && wb_adr_i == `AMM_ADR_LOWER && wb_sel_i[1:0] == 2'h3)
				lo_q <= wb_dat_i[DATA_W-1:0];
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	hold_no_strobe_a:
		assert property (!cycle_strobe_i |=> $stable(analog_result_o)) else $error("result moved");
	zero_on_dis_a:
		assert property (cycle_strobe_i && !enable_i && ctrl_q[2] |=> analog_result_o == '0) else $error("not zero");
	hold_on_dis_a:
		assert property (cycle_strobe_i && !enable_i && !ctrl_q[2] |=> $stable(analog_result_o)) else $error("not held");
	live_pass_a:
		assert property (cycle_strobe_i && enable_i && live_w |=> analog_result_o == $past(cl_w)) else $error("live");
	min_bound_a:
		assert property (cycle_strobe_i && enable_i && min_w |=> analog_result_o <= $past(cl_w)) else $error("min");
	max_bound_a:
		assert property (cycle_strobe_i && enable_i && max_w |=> analog_result_o >= $past(cl_w)) else $error("max");
	clamp_range_a:
		assert property (cycle_strobe_i && enable_i |=> analog_result_o >= lo_q && analog_result_o <= up_q)
			else $error("clamp");
endmodule : amm_min_max_properties
bind amm_min_max amm_min_max_properties #(.DATA_W(DATA_W)) u_props (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .cycle_strobe_i(cycle_strobe_i), .enable_i(enable_i),
	.analog_source_value_i(analog_source_value_i), .analog_result_o(analog_result_o), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o));
`default_nettype wire

// *** amm_pkg.sv ***
// types of the min/max tracker
package amm_pkg;

	typedef enum logic [1:0] {
		AMM_MODE_MIN  = 2'b00,
		AMM_MODE_MAX  = 2'b01,
		AMM_MODE_SEL  = 2'b10,
		AMM_MODE_LIVE = 2'b11
	} amm_mode_type;

	typedef struct packed {
		logic         from_block;
		logic         rst_on_dis;
		amm_mode_type mode;
	} amm_ctrl_type;

	typedef struct packed {
		logic valid;
		logic show_max;
		logic enable;
	} amm_stat_type;

endpackage : amm_pkg

// *** amm_source_model.sv ***
// partner model: analog source and program-cycle strobe
`timescale 1ns/1ns
`default_nettype none
module amm_source_model (
	input  wire logic               clock_i,
	input  wire logic               go_i,
	input  wire logic signed [15:0] level_i,
	output logic                    strobe_o,
	output logic signed [15:0]      value_o
);
	// ------
	// physical input limited to internal range 0..1000
	// ------
	always_ff @(posedge clock_i) begin
		strobe_o <= go_i;
		value_o  <= level_i < 0 ? 16'sh0000 : (level_i > 1000 ? 16'sh03e8 : level_i);
	end
endmodule : amm_source_model
`default_nettype wire

// *** analog_min_max_tracker_test.sv ***
// testbench of the min/max tracker
`timescale 1ns/1ns
`default_nettype none
`include "amm_cfg.svh"
module analog_min_max_tracker_test;
	logic               clock_i, rst_n_i, go, en, sel_x, strobe, cyc, stb, we, ack;
	logic [7:0]         adr;
	logic [31:0]        wdat, rdat, rd;
	logic signed [15:0] lvl, src, res;
	int                 fail_count, checks;
	amm_source_model u_src (.clock_i(clock_i), .go_i(go), .level_i(lvl), .strobe_o(strobe), .value_o(src));
	amm_min_max #(.DATA_W(16)) dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .cycle_strobe_i(strobe), .enable_i(en), .extreme_select_i(sel_x),
		.analog_source_value_i(src), .analog_result_o(res), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	// ------
	// bus, strobe and compare helpers
	// ------
	task automatic conclude;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock_i);
		{cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		{cyc, stb} <= 2'h0;
		if (n >= 20) begin
			fail_count++;
			$display("[ERR] %0t bus timeout", $time);
			conclude();
		end
	endtask : wb
	task automatic chk_bus(input logic [31:0] exp);
		checks++;
		if (rd !== exp) begin
			fail_count++;
			$display("[ERR] %0t read %h expected %h", $time, rd, exp);
		end
	endtask : chk_bus
	task automatic chk_res(input logic [15:0] exp);
		checks++;
		if (res !== exp) begin
			fail_count++;
			$display("[ERR] %0t result %h expected %h", $time, res, exp);
		end
	endtask : chk_res
	task automatic samp(input logic [15:0] v);
		@(posedge clock_i);
		{go, lvl} <= {1'b1, v};
		@(posedge clock_i);
		go <= 1'b0;
		repeat (2) @(posedge clock_i);
	endtask : samp
	// ------
	// scenarios
	// ------
	task automatic t_regs;
		wb(0, `AMM_ADR_CTRL, 0);
		chk_bus(32'h0);
		wb(0, `AMM_ADR_UPPER, 0);
		chk_bus(32'h0000_7fff);
		wb(0, `AMM_ADR_LOWER, 0);
		chk_bus(32'hffff_8000);
		wb(0, 8'h1c, 0);
		chk_bus(32'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic t_modes;
		logic [15:0] ex [5] = '{16'h00c8, 16'h0320, 16'h00c8, 16'h0320, 16'h0320};
		for (int i = 0; i < 5; i++) begin
			sel_x <= (i != 2);
			wb(1, `AMM_ADR_CTRL, i == 4 ? 32'h18 : 32'h10 | i);
			en <= 1'b1;
			samp(16'h01f4);
			samp(16'h00c8);
			samp(16'h0320);
			chk_res(ex[i]);
		end
		$display("test modes done");
	endtask : t_modes
	task automatic t_sel;
		wb(1, `AMM_ADR_CTRL, 32'h12);
		sel_x <= 1'b0;
		samp(16'h012c);
		samp(16'h0258);
		chk_res(16'h012c);
		sel_x <= 1'b1;
		samp(16'h0190);
		chk_res(16'h0258);
		sel_x <= 1'b0;
		samp(16'h0190);
		chk_res(16'h012c);
		wb(0, `AMM_ADR_MIN, 0);
		chk_bus(32'h0000_012c);
		wb(0, `AMM_ADR_MAX, 0);
		chk_bus(32'h0000_0258);
		wb(0, `AMM_ADR_STATUS, 0);
		chk_bus(32'h0000_0005);
		$display("test select done");
	endtask : t_sel
	task automatic t_dis;
		wb(1, `AMM_ADR_CTRL, 32'h10);
		samp(16'h01f4);
		en <= 1'b0;
		samp(16'h0064);
		chk_res(16'h01f4);
		wb(1, `AMM_ADR_CTRL, 32'h04);
		samp(16'h0064);
		chk_res(16'h0000);
		en <= 1'b1;
		samp(16'h02bc);
		chk_res(16'h02bc);
		$display("test disable done");
	endtask : t_dis
	task automatic t_clamp;
		wb(1, `AMM_ADR_CTRL, 32'h13);
		wb(1, `AMM_ADR_UPPER, 32'h2bc);
		wb(1, `AMM_ADR_LOWER, 32'h12c);
		samp(16'h0064);
		chk_res(16'h012c);
		samp(16'h0384);
		chk_res(16'h02bc);
		wb(0, `AMM_ADR_RESULT, 0);
		chk_bus(32'h2bc);
		$display("test clamp done");
	endtask : t_clamp
	initial begin
		{rst_n_i, go, en, sel_x, cyc, stb, we, adr, wdat, lvl} = '0;
		fail_count = 0;
		checks = 0;
		repeat (12) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		t_regs();
		t_modes();
		t_sel();
		t_dis();
		t_clamp();
		conclude();
	end
endmodule : analog_min_max_tracker_test
`default_nettype wire
